// ==== logic/adcs_config_port.sv ====
// serial configuration port, register map and sample output formatting
// assumes serial pins arrive asynchronously; serial clock well below the 100 MHz core clock
`timescale 1ns/1ps
`default_nettype none
module adcs_config_port #(
    parameter logic [7:0] PART_ID = 8'h5c, // arbitrary identification value
    parameter logic [1:0] SPEED_GRADE = 2'h0
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // serial pins
    input wire logic port_select_n,
    input wire logic serial_clock_or_format_strap,
    input wire logic sdioIn,
    output logic sdioOut,
    output logic sdioOe,
    // sample path
    input wire adcs_pkg::adcs_sample_t sampleIn,
    output adcs_pkg::adcs_sample_t sampleOut,
    // active power settings
    output logic standby_select,
    output logic [2:0] powerDownMode
);

    // ==============================================================
    // pin synchronisers
    logic sclkMeta, sclkSync, sclkPrev, csMeta, csSync, sdMeta, sdSync;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sclkMeta <= 1'b0;
            sclkSync <= 1'b0;
            sclkPrev <= 1'b0;
            csMeta <= 1'b1;
            csSync <= 1'b1;
            sdMeta <= 1'b0;
            sdSync <= 1'b0;
        end else begin
            sclkMeta <= serial_clock_or_format_strap;
            sclkSync <= sclkMeta;
            sclkPrev <= sclkSync;
            csMeta <= port_select_n;
            csSync <= csMeta;
            sdMeta <= sdioIn;
            sdSync <= sdMeta;
        end
    end

    logic sclkRise, sclkFall;
    assign sclkRise = sclkSync & ~sclkPrev;
    assign sclkFall = ~sclkSync & sclkPrev;

    // ==============================================================
    // format strap, caught once after reset release while the port is idle
    logic twosSelect, next_twosSelect, strapDone, next_strapDone;
    logic [1:0] strapCnt, next_strapCnt;
    always_comb begin
        next_twosSelect = twosSelect;
        next_strapDone = strapDone;
        next_strapCnt = strapCnt;
        if (!strapDone) begin
            if (strapCnt == adcs_pkg::STRAP_DELAY) begin
                next_strapDone = 1'b1;
                next_twosSelect = csSync & sclkSync;
            end else begin
                next_strapCnt = strapCnt + 2'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            twosSelect <= 1'b0;
            strapDone <= 1'b0;
            strapCnt <= 2'h0;
        end else begin
            twosSelect <= next_twosSelect;
            strapDone <= next_strapDone;
            strapCnt <= next_strapCnt;
        end
    end

    // ==============================================================
    // sample output: code and range flag share one register stage
    adcs_pkg::adcs_sample_t next_sampleOut;
    always_comb begin
        next_sampleOut.overRange = sampleIn.overRange; // R3
        next_sampleOut.code = sampleIn.code; // R1
        if (twosSelect) begin
            next_sampleOut.code = {~sampleIn.code[11], sampleIn.code[10:0]}; // R2
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sampleOut <= '0;
        end else begin
            sampleOut <= next_sampleOut;
        end
    end

    // ==============================================================
    // serial engine and registers
    adcs_pkg::adcs_state_t state, next_state;
    logic [15:0] instrSr, next_instrSr;
    logic [7:0] dataSr, next_dataSr;
    logic [7:0] txByte, next_txByte;
    logic [7:0] addr, next_addr;
    logic [4:0] bitCnt, next_bitCnt;
    logic [2:0] bytesLeft, next_bytesLeft;
    logic isRead, next_isRead;
    logic lsbFirst, next_lsbFirst;
    logic [7:0] modeMaster, next_modeMaster;
    logic [7:0] modeSlave, next_modeSlave;
    logic commitPend, next_commitPend;
    logic next_sdioOut, next_sdioOe;

    // read value of an address; unmapped and function-only slots read zero
    function automatic logic [7:0] readMux(input logic [7:0] a, input logic lsb, input logic [7:0] mm,
                                          input logic cp);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            adcs_pkg::ADDR_PORT_CONFIG: begin
                v = adcs_pkg::PORT_CONFIG_RESET; // R10
                v[adcs_pkg::PORT_LSB_HI] = lsb;
                v[adcs_pkg::PORT_LSB_LO] = lsb;
            end
            adcs_pkg::ADDR_PART_ID: v = PART_ID; // R12
            adcs_pkg::ADDR_GRADE: v = {3'h0, SPEED_GRADE, 3'h0}; // R13
            adcs_pkg::ADDR_POWER_MODE: v = mm & adcs_pkg::MODE_WRITE_MASK; // R18
            adcs_pkg::ADDR_COMMIT: v = {7'h00, cp}; // R6
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    logic [7:0] rxByte;
    logic [15:0] rxInstr;
    always_comb begin
        // lsb-first mode shifts toward the bottom so the word lands in order
        rxInstr = lsbFirst ? {sdSync, instrSr[15:1]} : {instrSr[14:0], sdSync}; // R17
        rxByte = lsbFirst ? {sdSync, dataSr[7:1]} : {dataSr[6:0], sdSync}; // R17
    end

    always_comb begin
        next_state = state;
        next_instrSr = instrSr;
        next_dataSr = dataSr;
        next_txByte = txByte;
        next_addr = addr;
        next_bitCnt = bitCnt;
        next_bytesLeft = bytesLeft;
        next_isRead = isRead;
        next_lsbFirst = lsbFirst;
        next_modeMaster = modeMaster;
        next_modeSlave = modeSlave;
        next_commitPend = 1'b0; // R19
        next_sdioOut = sdioOut;
        next_sdioOe = sdioOe;
        // commit copies masters to the active slaves one cycle after the write
        if (commitPend) begin
            next_modeSlave = modeMaster; // R6
        end
        case (state)
            adcs_pkg::ADCS_IDLE: begin
                next_sdioOe = 1'b0;
                if (!csSync && sclkRise) begin // R16
                    next_instrSr = rxInstr;
                    next_bitCnt = 5'h1;
                    next_state = adcs_pkg::ADCS_INSTR;
                end
            end
            adcs_pkg::ADCS_INSTR: begin
                if (sclkRise) begin
                    next_instrSr = rxInstr;
                    next_bitCnt = bitCnt + 5'h1;
                    if (bitCnt + 5'h1 == adcs_pkg::INSTR_BITS) begin // R15
                        next_isRead = rxInstr[adcs_pkg::INSTR_READ_BIT];
                        next_bytesLeft = {1'b0, rxInstr[adcs_pkg::INSTR_COUNT_POS +: 2]} + 3'h1;
                        next_addr = rxInstr[7:0];
                        next_txByte = readMux(rxInstr[7:0], lsbFirst, modeMaster, commitPend);
                        next_bitCnt = 5'h0;
                        next_state = adcs_pkg::ADCS_DATA;
                    end
                end
            end
            adcs_pkg::ADCS_DATA: begin
                // read data leaves on falling edges, host samples on rising
                if (isRead && sclkFall) begin
                    next_sdioOe = 1'b1; // R15
                    next_sdioOut = lsbFirst ? txByte[bitCnt[2:0]] : txByte[3'h7 - bitCnt[2:0]]; // R17
                end
                if (sclkRise) begin
                    next_dataSr = rxByte;
                    next_bitCnt = bitCnt + 5'h1;
                    if (bitCnt + 5'h1 == {1'b0, adcs_pkg::BYTE_BITS}) begin
                        next_bitCnt = 5'h0;
                        next_addr = addr - 8'h1;
                        next_bytesLeft = bytesLeft - 3'h1;
                        next_txByte = readMux(addr - 8'h1, lsbFirst, modeMaster, commitPend);
                        if (!isRead) begin
                            case (addr) // R4
                                adcs_pkg::ADDR_PORT_CONFIG: begin
                                    next_lsbFirst = rxByte[adcs_pkg::PORT_LSB_HI]; // R10
                                    if (rxByte[adcs_pkg::PORT_SRST_HI]) begin
                                        next_lsbFirst = 1'b0; // R8
                                        next_modeMaster = adcs_pkg::POWER_MODE_RESET;
                                        next_modeSlave = adcs_pkg::POWER_MODE_RESET;
                                    end
                                end
                                adcs_pkg::ADDR_POWER_MODE: begin
                                    next_modeMaster = rxByte & adcs_pkg::MODE_WRITE_MASK; // R5
                                end
                                adcs_pkg::ADDR_COMMIT: begin
                                    next_commitPend = rxByte[adcs_pkg::COMMIT_BIT]; // R6
                                end
                                default: begin
                                end
                            endcase
                        end
                        if (bytesLeft == 3'h1) begin
                            next_state = adcs_pkg::ADCS_DONE;
                        end
                    end
                end
            end
            adcs_pkg::ADCS_DONE: begin
                // release the data pin on the next rising edge
                if (sclkRise) begin
                    next_sdioOe = 1'b0;
                end
            end
            default: next_state = adcs_pkg::ADCS_IDLE;
        endcase
        // select high always ends the frame and frees the pin
        if (csSync) begin
            next_state = adcs_pkg::ADCS_IDLE; // R16
            next_sdioOe = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state <= adcs_pkg::ADCS_IDLE;
            lsbFirst <= 1'b0; // R8
            modeMaster <= adcs_pkg::POWER_MODE_RESET; // R8
            modeSlave <= adcs_pkg::POWER_MODE_RESET;
            commitPend <= 1'b0;
            sdioOut <= 1'b0;
            sdioOe <= 1'b0;
            bitCnt <= 5'h0;
            bytesLeft <= 3'h0;
            isRead <= 1'b0;
        end else begin
            state <= next_state;
            lsbFirst <= next_lsbFirst;
            modeMaster <= next_modeMaster;
            modeSlave <= next_modeSlave;
            commitPend <= next_commitPend;
            sdioOut <= next_sdioOut;
            sdioOe <= next_sdioOe;
            bitCnt <= next_bitCnt;
            bytesLeft <= next_bytesLeft;
            isRead <= next_isRead;
        end
    end

    // shift and address holders carry no default and survive reset
    always_ff @(posedge clock) begin
        instrSr <= next_instrSr; // R9
        dataSr <= next_dataSr;
        txByte <= next_txByte;
        addr <= next_addr;
    end

    // ==============================================================
    // active power outputs come from the slave copy only
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            standby_select <= 1'b0;
            powerDownMode <= adcs_pkg::PDM_NORMAL;
        end else begin
            standby_select <= next_modeSlave[adcs_pkg::MODE_STANDBY_BIT]; // R14
            powerDownMode <= next_modeSlave[2:0]; // R14
        end
    end

    // ==============================================================
    // checks
    property p_twos_msb;
        @(posedge clock) disable iff (!reset_n)
        twosSelect && $stable(twosSelect) |=> sampleOut.code == {~$past(sampleIn.code[11]), $past(sampleIn.code[10:0])};
    endproperty
    a_twos_msb: assert property (p_twos_msb) else $error("twos complement code wrong"); // R2
    property p_offset_pass;
        @(posedge clock) disable iff (!reset_n)
        !twosSelect && $stable(twosSelect) |=> sampleOut.code == $past(sampleIn.code);
    endproperty
    a_offset_pass: assert property (p_offset_pass) else $error("offset binary code altered"); // R1
    property p_range_aligned;
        @(posedge clock) disable iff (!reset_n)
        1'b1 |=> sampleOut.overRange == $past(sampleIn.overRange);
    endproperty
    a_range_aligned: assert property (p_range_aligned) else $error("range flag misaligned"); // R3
    property p_commit_clears;
        @(posedge clock) disable iff (!reset_n)
        commitPend |=> !commitPend ##1 !commitPend;
    endproperty
    a_commit_clears: assert property (p_commit_clears) else $error("transfer bit stuck"); // R19
    property p_commit_copies;
        @(posedge clock) disable iff (!reset_n)
        commitPend && !(state == adcs_pkg::ADCS_DATA) |=> ##1 powerDownMode == $past(modeMaster[2:0], 2);
    endproperty
    a_commit_copies: assert property (p_commit_copies) else $error("commit did not reach slaves"); // R6
    property p_master_only;
        @(posedge clock) disable iff (!reset_n)
        !commitPend && modeMaster != $past(modeMaster) && !lsbFirst && $stable(lsbFirst)
            |=> $stable(modeSlave);
    endproperty
    a_master_only: assert property (p_master_only) else $error("slave changed without commit"); // R5
    property p_reserved_zero;
        @(posedge clock) disable iff (!reset_n)
        1'b1 |-> (modeMaster & ~adcs_pkg::MODE_WRITE_MASK) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved mode bit set"); // R18
    property p_release_on_select;
        @(posedge clock) disable iff (!reset_n)
        csSync |=> !sdioOe && state == adcs_pkg::ADCS_IDLE;
    endproperty
    a_release_on_select: assert property (p_release_on_select) else $error("pin driven outside frame"); // R16
    property p_write_no_drive;
        @(posedge clock) disable iff (!reset_n)
        state == adcs_pkg::ADCS_DATA && !isRead && !sdioOe |=> !sdioOe;
    endproperty
    a_write_no_drive: assert property (p_write_no_drive) else $error("pin driven during write"); // R15

endmodule
`default_nettype wire

// ==== common/adcs_pkg.sv ====
// constants, types and register map of the converter configuration port
// assumes one 100 MHz clock and a synchronous active-low reset in the user logic
//
// Overview of operation
// R1: samples leave in offset binary by default, out-of-range inputs already clamped.
// R2: twos complement output is the offset binary word with its top bit inverted.
// R3: out-of-range flag travels in the same pipeline stage as its data word.
// R4: addresses decode into chip configuration, transfer register and converter function regions.
// R5: function register writes land in masters; host sets transfer bit to commit.
// R6: transfer register holds only bit 0; setting it copies masters into slaves.
// R7: host writes undefined addresses only with defaults and reserved bits as zero.
// R8: leaving reset loads the listed defaults into the critical registers.
// R9: registers without a listed default keep their value across reset.
// R10: port config holds lsb-first in bits 6,1, soft reset in 5,2, default 0x18.
// R11: host mirrors upper nibble control bits into the lower nibble when writing.
// R12: part identifier is a fixed read-only byte; writes have no effect.
// R13: grade register is read-only with speed grade in bits 4 to 3.
// R14: modes register: bit 5 standby, bits 2 to 0 internal power-down, default zero.
// R15: a 16-bit instruction opens each frame: read flag, byte count, then address.
// R16: frame starts on select low qualified by the next rising serial clock.
// R17: port shifts msb first after power-up, lsb first only when configured.
// R18: reserved bits of defined registers read back as zero.
// R19: the transfer bit clears itself once the copy has been made.
package adcs_pkg;

    // ==============================================================
    // register offsets
    localparam logic [7:0] ADDR_PORT_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_PART_ID = 8'h01;
    localparam logic [7:0] ADDR_GRADE = 8'h02;
    localparam logic [7:0] ADDR_POWER_MODE = 8'h08;
    localparam logic [7:0] ADDR_FUNC_LAST = 8'h2a;
    localparam logic [7:0] ADDR_COMMIT = 8'hff;

    // ==============================================================
    // field positions and reset values
    localparam int PORT_LSB_HI = 6;
    localparam int PORT_LSB_LO = 1;
    localparam int PORT_SRST_HI = 5;
    localparam int PORT_SRST_LO = 2;
    localparam logic [7:0] PORT_CONFIG_RESET = 8'h18;
    localparam int MODE_STANDBY_BIT = 5;
    localparam logic [7:0] MODE_WRITE_MASK = 8'h27;
    localparam logic [7:0] POWER_MODE_RESET = 8'h00;
    localparam int COMMIT_BIT = 0;
    localparam int GRADE_POS = 3;
    localparam int INSTR_READ_BIT = 15;
    localparam int INSTR_COUNT_POS = 13;

    // ==============================================================
    // counts
    localparam logic [4:0] INSTR_BITS = 5'h10;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [1:0] STRAP_DELAY = 2'h3;

    // ==============================================================
    // power-down codes and frame states
    localparam logic [2:0] PDM_NORMAL = 3'h0;
    localparam logic [2:0] PDM_FULL = 3'h1;
    localparam logic [2:0] PDM_STANDBY = 3'h2;

    typedef enum logic [3:0] {
        ADCS_IDLE = 4'h1,
        ADCS_INSTR = 4'h2,
        ADCS_DATA = 4'h4,
        ADCS_DONE = 4'h8
    } adcs_state_t;

    // one converted sample with its range flag
    typedef struct packed {
        logic overRange;
        logic [11:0] code;
    } adcs_sample_t;

endpackage

// ==== tb/adcs_spi_host.sv ====
// ==============================================================
// serial host model for the converter configuration port
// assumes the bench calls frame() from the falling edge of the core clock
`timescale 1ns/1ps
`default_nettype none
module adcs_spi_host #(
    parameter int HALF = 5
) (
    // pacing clock
    input wire logic clock,
    // strap level shown on the clock pin between frames, bit order in use
    input wire logic strapHigh,
    input wire logic lsbFirst,
    // serial pins
    output logic port_select_n,
    output logic serial_clock_or_format_strap,
    output logic sdioIn,
    input wire logic sdioOut,
    input wire logic sdioOe
);
    logic inFrame = 1'b0;
    logic sclkBit = 1'b0;
    logic hostBit = 1'b0;
    logic selBit = 1'b1;
    logic oeSeen = 1'b1;

    // ==============================================================
    // pins: clock stands low inside frames, shows the strap outside
    assign port_select_n = selBit;
    assign serial_clock_or_format_strap = inFrame ? sclkBit : strapHigh;
    // undriven wire has no pull, so a released pin toggles rather than holding
    assign sdioIn = sdioOe ? sdioOut : hostBit;

    // ==============================================================
    // timing helpers
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask

    // data set while low, held through the high half for the device sample
    task automatic shiftBit(input logic b, input logic drive, output logic got);
        hostBit = drive ? b : ~hostBit;
        tick(HALF);
        got = sdioIn;
        if (!drive) begin
            oeSeen = oeSeen & sdioOe;
        end
        sclkBit = 1'b1;
        tick(HALF);
        sclkBit = 1'b0;
    endtask

    // ==============================================================
    // one whole frame: instruction then cnt+1 bytes, top byte first
    task automatic frame(input logic rd, input logic [7:0] addr, input logic [1:0] cnt,
                         input logic [31:0] wdata, output logic [31:0] rdata);
        logic [15:0] instr;
        logic got;
        int i;
        int k;
        int j;
        int idx;
        instr = {rd, cnt, 5'h00, addr};
        rdata = 32'h0;
        oeSeen = 1'b1;
        inFrame = 1'b1;
        selBit = 1'b0;
        tick(HALF);
        for (i = 0; i < 16; i++) begin
            shiftBit(instr[lsbFirst ? i : 15 - i], 1'b1, got);
        end
        for (k = 0; k <= int'(cnt); k++) begin
            for (j = 0; j < 8; j++) begin
                idx = lsbFirst ? 24 - 8 * k + j : 31 - 8 * k - j;
                shiftBit(wdata[idx], !rd, got);
                rdata[idx] = got;
            end
        end
        tick(HALF);
        selBit = 1'b1;
        inFrame = 1'b0;
        tick(2 * HALF);
    endtask
endmodule
`default_nettype wire

// ==== tb/adcs_config_port_tb.sv ====
// ==============================================================
// self-checking bench for the configuration port and sample formatting
// assumes the host model in adcs_spi_host and the design package
`timescale 1ns/1ps
`default_nettype none
module adcs_config_port_tb;
    localparam logic [7:0] TB_PART_ID = 8'h3c; // arbitrary identification value
    localparam logic [1:0] TB_GRADE = 2'h1;
    localparam logic [7:0] GRADE_BYTE = {3'h0, TB_GRADE, 3'h0};
    typedef struct packed {
        adcs_pkg::adcs_sample_t stim;
        adcs_pkg::adcs_sample_t expOb;
    } adcs_row_t;

    logic clock, reset_n, selN, sclk, sdio, sdioOut, sdioOe, standbySel, strapHigh, lsbFirst;
    logic [2:0] pdm;
    logic [31:0] rdata;
    adcs_pkg::adcs_sample_t sampleIn, sampleOut;
    int mismatches = 0;
    int checkCount = 0;
    // plain offset binary passes as clamped; flag rides with its word
    adcs_row_t rows [6] = '{
        '{'{1'b1, 12'h000}, '{1'b1, 12'h000}}, '{'{1'b0, 12'h000}, '{1'b0, 12'h000}},
        '{'{1'b0, 12'h800}, '{1'b0, 12'h800}}, '{'{1'b0, 12'hfff}, '{1'b0, 12'hfff}},
        '{'{1'b1, 12'hfff}, '{1'b1, 12'hfff}}, '{'{1'b0, 12'h5a3}, '{1'b0, 12'h5a3}}};
    // standby code first so a missing commit is visible against the reset state
    logic [7:0] modeCodes [3] = '{8'h02, 8'h00, 8'h21};

    // ==============================================================
    // clock, design and host
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    adcs_config_port #(.PART_ID(TB_PART_ID), .SPEED_GRADE(TB_GRADE)) i_dut (
        .clock(clock), .reset_n(reset_n), .port_select_n(selN),
        .serial_clock_or_format_strap(sclk), .sdioIn(sdio), .sdioOut(sdioOut), .sdioOe(sdioOe),
        .sampleIn(sampleIn), .sampleOut(sampleOut), .standby_select(standbySel), .powerDownMode(pdm));

    adcs_spi_host #(.HALF(5)) i_host (
        .clock(clock), .strapHigh(strapHigh), .lsbFirst(lsbFirst), .port_select_n(selN),
        .serial_clock_or_format_strap(sclk), .sdioIn(sdio), .sdioOut(sdioOut), .sdioOe(sdioOe));

    // ==============================================================
    // compares and closing
    task automatic checkByte(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask);
        checkCount++;
        if ((got & mask) !== (exp & mask)) begin
            mismatches++;
            $display("CHECK FAILED at %0t: byte got %h want %h", $time, got, exp);
        end
    endtask

    task automatic checkSample(input adcs_pkg::adcs_sample_t got, input adcs_pkg::adcs_sample_t exp);
        checkCount++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: sample got %h want %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ==============================================================
    // bus helpers: single-byte frames
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        logic [31:0] dummy;
        i_host.frame(1'b0, addr, 2'h0, {data, 24'h0}, dummy);
    endtask

    task automatic rdChk(input logic [7:0] addr, input logic [7:0] exp, input logic [7:0] mask);
        logic [31:0] got;
        i_host.frame(1'b1, addr, 2'h0, 32'h0, got);
        checkByte(got[31:24], exp, mask);
    endtask

    // back-to-back samples; twos flips only the top code bit
    task automatic runRows(input logic twos);
        adcs_pkg::adcs_sample_t exp;
        foreach (rows[r]) begin
            sampleIn = rows[r].stim;
            @(negedge clock);
            exp = rows[r].expOb;
            exp.code[11] = exp.code[11] ^ twos;
            checkSample(sampleOut, exp);
        end
    endtask

    // ==============================================================
    // hang guard, well beyond the expected run of about 8k cycles
    initial begin
        repeat (40000) @(posedge clock);
        mismatches++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        report_and_stop;
    end

    // ==============================================================
    // main sequence
    initial begin
        reset_n = 1'b0;
        strapHigh = 1'b0;
        lsbFirst = 1'b0;
        sampleIn = '0;
        repeat (5) @(negedge clock);
        reset_n = 1'b1;
        repeat (8) @(negedge clock);
        runRows(1'b0);
        checkByte({4'h0, standbySel, pdm}, 8'h00, 8'hff);
        rdChk(adcs_pkg::ADDR_PORT_CONFIG, 8'h18, 8'hff);
        rdChk(adcs_pkg::ADDR_COMMIT, 8'h00, 8'hff);
        rdChk(adcs_pkg::ADDR_POWER_MODE, 8'h00, 8'hff);
        rdChk(adcs_pkg::ADDR_PART_ID, TB_PART_ID, 8'hff);
        i_host.frame(1'b1, adcs_pkg::ADDR_GRADE, 2'h2, 32'h0, rdata);
        checkByte(rdata[31:24], GRADE_BYTE, 8'hf8);
        checkByte(rdata[23:16], TB_PART_ID, 8'hff);
        checkByte(rdata[15:8], 8'h18, 8'hff);
        checkByte({7'h0, i_host.oeSeen}, 8'h01, 8'hff);
        wr(adcs_pkg::ADDR_PART_ID, ~TB_PART_ID);
        wr(adcs_pkg::ADDR_GRADE, 8'hff);
        rdChk(adcs_pkg::ADDR_PART_ID, TB_PART_ID, 8'hff);
        rdChk(adcs_pkg::ADDR_GRADE, GRADE_BYTE, 8'hf8);
        // lsb-first entered with mirrored nibbles, left again by soft reset
        wr(adcs_pkg::ADDR_PORT_CONFIG, 8'h5a);
        lsbFirst = 1'b1;
        rdChk(adcs_pkg::ADDR_PORT_CONFIG, 8'h5a, 8'hff);
        rdChk(adcs_pkg::ADDR_PART_ID, TB_PART_ID, 8'hff);
        wr(adcs_pkg::ADDR_PORT_CONFIG, 8'h3c);
        lsbFirst = 1'b0;
        repeat (10) @(negedge clock);
        rdChk(adcs_pkg::ADDR_PORT_CONFIG, 8'h18, 8'hff);
        // each power code: master only until committed
        foreach (modeCodes[m]) begin
            wr(adcs_pkg::ADDR_POWER_MODE, modeCodes[m]);
            checkByte({4'h0, standbySel, pdm}, (m == 0) ? 8'h00 : {4'h0, modeCodes[m - 1][5],
                      modeCodes[m - 1][2:0]}, 8'hff);
            rdChk(adcs_pkg::ADDR_POWER_MODE, modeCodes[m], 8'hff);
            wr(adcs_pkg::ADDR_COMMIT, 8'h01);
            checkByte({4'h0, standbySel, pdm}, {4'h0, modeCodes[m][5], modeCodes[m][2:0]}, 8'hff);
            rdChk(adcs_pkg::ADDR_COMMIT, 8'h00, 8'hff);
        end
        wr(adcs_pkg::ADDR_POWER_MODE, 8'hff);
        rdChk(adcs_pkg::ADDR_POWER_MODE, 8'h27, 8'hff);
        // second reset with the strap high selects twos complement
        strapHigh = 1'b1;
        reset_n = 1'b0;
        repeat (5) @(negedge clock);
        reset_n = 1'b1;
        repeat (8) @(negedge clock);
        strapHigh = 1'b0;
        repeat (4) @(negedge clock);
        checkByte({4'h0, standbySel, pdm}, 8'h00, 8'hff);
        rdChk(adcs_pkg::ADDR_POWER_MODE, 8'h00, 8'hff);
        rdChk(adcs_pkg::ADDR_PORT_CONFIG, 8'h18, 8'hff);
        rdChk(adcs_pkg::ADDR_PART_ID, TB_PART_ID, 8'hff);
        runRows(1'b1);
        report_and_stop;
    end
endmodule
`default_nettype wire
